// File: src/ppf_port_pin_function_select.sv
// port one pin function select and port two general i/o with a wishbone slave
//
// Operation
// - mode bit 4 selects pin four: zero general i/o, one pwm output.
// - mode bits 3 and 1 read zero, bit 2 reads one, writes ignored.
// - mode bit 0 puts watch clock on pin zero, overriding its direction.
// - pins seven to five become interrupt inputs when selected; seven also triggers timer.
// - pin four drives pwm when selected, else direction bit picks input or output.
// - port one floats in reset and standby, works in active and subactive, holds otherwise.
// - in standby a port one pin with pull-up enabled shows high.
// - pull-up is on only for direction zero with pull-up bit one.
// - reset switches every port one pull-up off.
// - port two has three general i/o pins in bits 2 to 0.
// - port two data read gives latch for outputs, pin level for inputs.
// - port two data bits 7 to 3 read zero and ignore writes.
// - reset clears port two data to zero.
// - port one direction one means output; settings apply only in general i/o mode.
// - port one data read gives latch for outputs, pin level for inputs.
// - port one direction register is write-only and reads all ones.
// - reset loads the pin mode register with only bit 2 set.
`timescale 1ns/10ps
module ppf_port_pin_function_select
    import ppf_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_N_I,
    // wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [17:0] ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // power mode from the system controller, same clock
    input  wire logic [2:0]  POWER_MODE_I,
    // on-chip peripherals
    input  wire logic        PWM_I,
    input  wire logic        WATCH_CLK_I,
    output logic      [2:0]  IRQ_N_O,
    output logic             TRIG_O,
    // port one pins, bits 7 to 4 and 0 used
    input  wire logic [7:0]  P1_IN_I,
    output logic      [7:0]  P1_OUT_O,
    output logic      [7:0]  P1_OE_O,
    output logic      [7:0]  P1_PULLUP_O,
    // port two pins
    input  wire logic [2:0]  P2_IN_I,
    output logic      [2:0]  P2_OUT_O,
    output logic      [2:0]  P2_OE_O
);
    // registers and next values
    logic [7:0]  port_one_data_q,     port_one_data_d;
    logic [7:0]  port_one_direction_q, port_one_direction_d;
    logic [7:0]  port_one_pullup_enable_q, port_one_pullup_enable_d;
    logic [7:0]  port_one_pin_mode_q, port_one_pin_mode_d;
    logic [2:0]  port_two_data_q,     port_two_data_d;
    logic [2:0]  port_two_direction_q, port_two_direction_d;
    logic        ack_q,   ack_d;
    logic [31:0] rdata_q, rdata_d;
    // synchronisers and pin state
    logic [7:0]  p1_meta_q, p1_sync_q;
    logic [2:0]  p2_meta_q, p2_sync_q;
    logic [7:0]  p1_oe_q,  p1_oe_d;
    logic [7:0]  p1_out_q, p1_out_d;
    logic [7:0]  p1_pu_q,  p1_pu_d;
    logic [2:0]  p2_oe_q,  p2_oe_d;
    logic [2:0]  p2_out_q, p2_out_d;
    logic [2:0]  irq_n_q,  irq_n_d;
    logic        trig_q,   trig_d;
    // decode
    logic        req;
    logic        wr;
    logic [15:0] idx;
    ppf_pwr_e    pm;
    logic        functional;
    logic        hold;

    ppf_cfg_if cfg ();

    // read value of a mixed latch/pin data register
    function automatic logic [7:0] mix_read(input logic [7:0] latch, input logic [7:0] pin,
                                            input logic [7:0] dir, input logic [7:0] mask);
        mix_read = ((latch & dir) | (pin & ~dir)) & mask;
    endfunction : mix_read

    // register read mux; unmapped indices read zero
    function automatic logic [7:0] reg_read(input logic [15:0] index);
        unique case (index)
            IDX_P1_DATA:   reg_read = mix_read(port_one_data_q, p1_sync_q,
                                               port_one_direction_q, P1_PIN_MASK);
            IDX_P1_DIR:    reg_read = WO_READ;
            IDX_P1_PULLUP: reg_read = port_one_pullup_enable_q & P1_PIN_MASK;
            IDX_P1_MODE:   reg_read = (port_one_pin_mode_q & P1_PIN_MASK) | MODE_FIXED;
            IDX_P2_DATA:   reg_read = mix_read({5'h00, port_two_data_q}, {5'h00, p2_sync_q},
                                               {5'h00, port_two_direction_q}, 8'h07);
            IDX_P2_DIR:    reg_read = WO_READ;
            default:       reg_read = 8'h00;
        endcase
    endfunction : reg_read

    assign req = CYC_I & STB_I & ~ack_q;
    assign wr  = req & WE_I & SEL_I[0];
    assign idx = ADR_I[17:2];

    // bus slave and register next values; write takes effect on the request edge
    always_comb begin
        port_one_data_d          = port_one_data_q;
        port_one_direction_d     = port_one_direction_q;
        port_one_pullup_enable_d = port_one_pullup_enable_q;
        port_one_pin_mode_d      = port_one_pin_mode_q;
        port_two_data_d          = port_two_data_q;
        port_two_direction_d     = port_two_direction_q;
        ack_d   = req;
        rdata_d = req ? {24'h000000, reg_read(idx)} : 32'h00000000;
        if (wr) begin
            unique case (idx)
                IDX_P1_DATA:   port_one_data_d = DAT_I[7:0] & P1_PIN_MASK;
                IDX_P1_DIR:    port_one_direction_d = DAT_I[7:0] & P1_PIN_MASK;
                IDX_P1_PULLUP: port_one_pullup_enable_d = DAT_I[7:0] & P1_PIN_MASK;
                IDX_P1_MODE:   port_one_pin_mode_d = (DAT_I[7:0] & P1_PIN_MASK) | MODE_FIXED;
                IDX_P2_DATA:   port_two_data_d = DAT_I[2:0];
                IDX_P2_DIR:    port_two_direction_d = DAT_I[2:0];
                default:       ; // unmapped writes are acknowledged and dropped
            endcase
        end
    end

    // register file flops
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            port_one_data_q          <= RST_P1_DATA;
            port_one_direction_q     <= RST_P1_DIR;
            port_one_pullup_enable_q <= RST_P1_PULLUP;
            port_one_pin_mode_q      <= RST_P1_MODE;
            port_two_data_q          <= RST_P2_DATA;
            port_two_direction_q     <= RST_P2_DIR;
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            port_one_data_q          <= port_one_data_d;
            port_one_direction_q     <= port_one_direction_d;
            port_one_pullup_enable_q <= port_one_pullup_enable_d;
            port_one_pin_mode_q      <= port_one_pin_mode_d;
            port_two_data_q          <= port_two_data_d;
            port_two_direction_q     <= port_two_direction_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // two-flop synchronisers for pin levels
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            p1_meta_q <= 8'h00;
            p1_sync_q <= 8'h00;
            p2_meta_q <= 3'h0;
            p2_sync_q <= 3'h0;
        end else begin
            p1_meta_q <= P1_IN_I;
            p1_sync_q <= p1_meta_q;
            p2_meta_q <= P2_IN_I;
            p2_sync_q <= p2_meta_q;
        end
    end

    // settings to the pin mux
    assign cfg.p1_data   = port_one_data_q;
    assign cfg.p1_dir    = port_one_direction_q;
    assign cfg.p1_pullup = port_one_pullup_enable_q;
    assign cfg.p1_mode   = port_one_pin_mode_q;
    assign cfg.p2_data   = port_two_data_q;
    assign cfg.p2_dir    = port_two_direction_q;
    assign cfg.pwm       = PWM_I;
    assign cfg.wclk      = WATCH_CLK_I;

    ppf_pin_mux ppf_pin_mux_i (
        .cfg (cfg.mux)
    );

    // power mode decode; unknown codes hold the pins rather than glitch them
    assign pm = ppf_pwr_e'(POWER_MODE_I);
    always_comb begin
        functional = 1'b0;
        hold       = 1'b0;
        unique case (pm)
            PM_ACTIVE, PM_SUBACTIVE:        functional = 1'b1;
            PM_SLEEP, PM_SUBSLEEP, PM_WATCH: hold = 1'b1;
            PM_STANDBY:                     ;
            default:                        hold = 1'b1;
        endcase
    end

    // pin state: follow the mux, freeze, or float in standby
    always_comb begin
        p1_oe_d  = p1_oe_q;
        p1_out_d = p1_out_q;
        p1_pu_d  = p1_pu_q;
        p2_oe_d  = p2_oe_q;
        p2_out_d = p2_out_q;
        if (functional) begin
            p1_oe_d  = cfg.p1_oe;
            p1_out_d = cfg.p1_out;
            p1_pu_d  = cfg.p1_pu_en;
            p2_oe_d  = cfg.p2_oe;
            p2_out_d = cfg.p2_out;
        end else if (!hold) begin
            p1_oe_d = 8'h00;
            p2_oe_d = 3'h0;
            p1_pu_d = cfg.p1_pu_en;
        end
    end

    // peripheral inputs get the pin level only while their function is selected
    always_comb begin
        irq_n_d[2] = port_one_pin_mode_q[MODE_EXT_INT3] ? p1_sync_q[7] : 1'b1;
        irq_n_d[1] = port_one_pin_mode_q[MODE_EXT_INT2] ? p1_sync_q[6] : 1'b1;
        irq_n_d[0] = port_one_pin_mode_q[MODE_EXT_INT1] ? p1_sync_q[5] : 1'b1;
        trig_d     = port_one_pin_mode_q[MODE_EXT_INT3] & p1_sync_q[7];
    end

    // pin and peripheral flops; reset leaves every pin floating
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            p1_oe_q  <= 8'h00;
            p1_out_q <= 8'h00;
            p1_pu_q  <= 8'h00;
            p2_oe_q  <= 3'h0;
            p2_out_q <= 3'h0;
            irq_n_q  <= 3'h7;
            trig_q   <= 1'b0;
        end else begin
            p1_oe_q  <= p1_oe_d;
            p1_out_q <= p1_out_d;
            p1_pu_q  <= p1_pu_d;
            p2_oe_q  <= p2_oe_d;
            p2_out_q <= p2_out_d;
            irq_n_q  <= irq_n_d;
            trig_q   <= trig_d;
        end
    end

    // outputs
    assign DAT_O       = rdata_q;
    assign ACK_O       = ack_q;
    assign IRQ_N_O     = irq_n_q;
    assign TRIG_O      = trig_q;
    assign P1_OUT_O    = p1_out_q;
    assign P1_OE_O     = p1_oe_q;
    assign P1_PULLUP_O = p1_pu_q;
    assign P2_OUT_O    = p2_out_q;
    assign P2_OE_O     = p2_oe_q;

    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    AST_MODE_READ: assert property (
        req && !WE_I && idx == IDX_P1_MODE |=> ACK_O && DAT_O[3:1] == 3'b010)
        else $error("mode register reserved bits read wrong");
    AST_PWM_DRIVE: assert property (
        functional && port_one_pin_mode_q[MODE_PWM] |=> P1_OE_O[4] && P1_OUT_O[4] == $past(PWM_I))
        else $error("pin four not driving pwm");
    AST_WCLK_DRIVE: assert property (
        functional && port_one_pin_mode_q[MODE_WCLK] |=> P1_OE_O[0] && P1_OUT_O[0] == $past(WATCH_CLK_I))
        else $error("pin zero not driving watch clock");
    AST_IRQ_INPUT: assert property (
        functional && port_one_pin_mode_q[MODE_EXT_INT3] |=> !P1_OE_O[7])
        else $error("interrupt pin still driven");
    AST_IRQ_FWD: assert property (
        port_one_pin_mode_q[MODE_EXT_INT1] |=> IRQ_N_O[0] == $past(p1_sync_q[5]))
        else $error("interrupt input not forwarded");
    AST_STANDBY_FLOAT: assert property (
        pm == PM_STANDBY |=> P1_OE_O == 8'h00 && P2_OE_O == 3'h0)
        else $error("pin driven in standby");
    AST_HOLD_STATE: assert property (
        hold |=> $stable(P1_OE_O) && $stable(P1_OUT_O) && $stable(P2_OE_O))
        else $error("pin state changed in hold mode");
    AST_PULLUP_DIR: assert property (
        functional |=> (P1_PULLUP_O & $past(port_one_direction_q)) == 8'h00)
        else $error("pull-up on for output pin");
    AST_P2_READ: assert property (
        req && !WE_I && idx == IDX_P2_DATA |=> DAT_O[7:0] == {5'h00,
            ($past(port_two_data_q) & $past(port_two_direction_q)) |
            ($past(p2_sync_q) & ~$past(port_two_direction_q))})
        else $error("port two data read wrong");
    AST_DIR_READ: assert property (
        req && !WE_I && idx == IDX_P1_DIR |=> DAT_O[7:0] == 8'hff)
        else $error("direction register not reading ones");
    AST_ACK_PULSE: assert property (
        req |=> ACK_O ##1 !ACK_O)
        else $error("ack not a single cycle");

    COV_PWM: cover property (functional && port_one_pin_mode_q[MODE_PWM] ##1 P1_OE_O[4]);
    COV_STANDBY: cover property (pm == PM_STANDBY ##1 P1_PULLUP_O != 8'h00);
    COV_P2_READ: cover property (req && !WE_I && idx == IDX_P2_DATA ##1 ACK_O);
    COV_IRQ: cover property (port_one_pin_mode_q[MODE_EXT_INT3] && !IRQ_N_O[2]);
endmodule : ppf_port_pin_function_select

// File: src/ppf_pkg.sv
// constants, types and register map of the port pin function select block
package ppf_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_P1_DATA   = 16'hffd4;
    localparam logic [15:0] IDX_P1_DIR    = 16'hffe4;
    localparam logic [15:0] IDX_P1_PULLUP = 16'hffed;
    localparam logic [15:0] IDX_P1_MODE   = 16'hfffc;
    localparam logic [15:0] IDX_P2_DATA   = 16'hffd5;
    localparam logic [15:0] IDX_P2_DIR    = 16'hffe5;
    // values after reset
    localparam logic [7:0]  RST_P1_DATA   = 8'h00;
    localparam logic [7:0]  RST_P1_DIR    = 8'h00;
    localparam logic [7:0]  RST_P1_PULLUP = 8'h00;
    localparam logic [7:0]  RST_P1_MODE   = 8'h04;
    localparam logic [2:0]  RST_P2_DATA   = 3'h0;
    localparam logic [2:0]  RST_P2_DIR    = 3'h0;
    // implemented bits of port one (pins 7 to 4 and 0)
    localparam logic [7:0]  P1_PIN_MASK   = 8'hf1;
    // reserved mode bit 2 reads one
    localparam logic [7:0]  MODE_FIXED    = 8'h04;
    localparam logic [7:0]  WO_READ       = 8'hff;
    // mode bit positions
    localparam int          MODE_EXT_INT3 = 7;
    localparam int          MODE_EXT_INT2 = 6;
    localparam int          MODE_EXT_INT1 = 5;
    localparam int          MODE_PWM      = 4;
    localparam int          MODE_WCLK     = 0;
    // power mode codes, gray along active-subactive-sleep-subsleep path
    typedef enum logic [2:0] {
        PM_ACTIVE    = 3'h0,
        PM_SUBACTIVE = 3'h1,
        PM_SLEEP     = 3'h3,
        PM_SUBSLEEP  = 3'h2,
        PM_WATCH     = 3'h6,
        PM_STANDBY   = 3'h7
    } ppf_pwr_e;
endpackage : ppf_pkg

// File: src/ppf_cfg_if.sv
// settings and resulting pin controls passed between register file and pin mux
`timescale 1ns/10ps
interface ppf_cfg_if;
    logic [7:0] p1_data;
    logic [7:0] p1_dir;
    logic [7:0] p1_pullup;
    logic [7:0] p1_mode;
    logic [2:0] p2_data;
    logic [2:0] p2_dir;
    logic       pwm;
    logic       wclk;
    logic [7:0] p1_oe;
    logic [7:0] p1_out;
    logic [7:0] p1_pu_en;
    logic [2:0] p2_oe;
    logic [2:0] p2_out;
    modport regs (output p1_data, p1_dir, p1_pullup, p1_mode, p2_data, p2_dir, pwm, wclk,
                  input  p1_oe, p1_out, p1_pu_en, p2_oe, p2_out);
    modport mux  (input  p1_data, p1_dir, p1_pullup, p1_mode, p2_data, p2_dir, pwm, wclk,
                  output p1_oe, p1_out, p1_pu_en, p2_oe, p2_out);
endinterface : ppf_cfg_if

// File: src/ppf_pin_mux.sv
// pin function selection: direction, drive and pull-up per pin
`timescale 1ns/10ps
module ppf_pin_mux
    import ppf_pkg::*;
(
    ppf_cfg_if.mux cfg
);
    // peripheral functions override the direction bit while selected
    always_comb begin
        cfg.p1_oe  = cfg.p1_dir & P1_PIN_MASK;
        cfg.p1_out = cfg.p1_data & P1_PIN_MASK;
        // interrupt pins become inputs whatever the direction says
        if (cfg.p1_mode[MODE_EXT_INT3]) cfg.p1_oe[7] = 1'b0;
        if (cfg.p1_mode[MODE_EXT_INT2]) cfg.p1_oe[6] = 1'b0;
        if (cfg.p1_mode[MODE_EXT_INT1]) cfg.p1_oe[5] = 1'b0;
        if (cfg.p1_mode[MODE_PWM]) begin
            cfg.p1_oe[4]  = 1'b1;
            cfg.p1_out[4] = cfg.pwm;
        end
        if (cfg.p1_mode[MODE_WCLK]) begin
            cfg.p1_oe[0]  = 1'b1;
            cfg.p1_out[0] = cfg.wclk;
        end
    end

    // pull-up only on input-direction pins with the enable set
    assign cfg.p1_pu_en = ~cfg.p1_dir & cfg.p1_pullup & P1_PIN_MASK;
    // port two is plain general i/o here
    assign cfg.p2_oe  = cfg.p2_dir;
    assign cfg.p2_out = cfg.p2_data;
endmodule : ppf_pin_mux

// File: sim/ppf_pin_model.sv
// board side of the pins: external drivers, pull-ups and peripheral signal sources
`timescale 1ns/10ps
module ppf_pin_model (
    // clock
    input  wire logic       clk_i,
    // port one from the block and from the board
    input  wire logic [7:0] p1_out_i,
    input  wire logic [7:0] p1_oe_i,
    input  wire logic [7:0] p1_pu_i,
    input  wire logic [7:0] p1_ext_i,
    input  wire logic [7:0] p1_ext_en_i,
    output logic      [7:0] p1_lvl_o,
    // port two
    input  wire logic [2:0] p2_out_i,
    input  wire logic [2:0] p2_oe_i,
    input  wire logic [2:0] p2_ext_i,
    output logic      [2:0] p2_lvl_o,
    // peripheral sources
    output logic            pwm_o,
    output logic            wclk_o
);
    logic [2:0] cnt = 3'h0;
    // free counter feeds the peripherals and the floating-pin pattern
    always @(posedge clk_i) begin
        cnt <= cnt + 3'h1;
    end
    assign pwm_o  = cnt[1];
    assign wclk_o = cnt[0];
    // a floating pin toggles so a stale value cannot pass for a match
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            p1_lvl_o[k] = p1_oe_i[k] ? p1_out_i[k] : p1_ext_en_i[k] ? p1_ext_i[k] : p1_pu_i[k] ? 1'b1 : cnt[0];
        end
    end
    // port two always has a board driver when not driven by the block
    assign p2_lvl_o = (p2_oe_i & p2_out_i) | (~p2_oe_i & p2_ext_i);
endmodule : ppf_pin_model

// File: sim/ppf_port_pin_function_select_tb_top.sv
// self-checking bench for the port pin function select block
`timescale 1ns/10ps
module ppf_port_pin_function_select_tb_top;
    import ppf_pkg::*;
    logic clk, rst_n, cyc, stb, we, ack, pwm, wclk, trig;
    logic [17:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r;
    logic [2:0]  pm, irq_n, p2_ext, p2_out, p2_oe, p2_lvl;
    logic [7:0]  p1_ext, p1_ext_en, p1_out, p1_oe, p1_pu, p1_lvl;
    int failures = 0;
    int checks = 0;

    ppf_port_pin_function_select ppf_port_pin_function_select_i (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .POWER_MODE_I(pm), .PWM_I(pwm),
        .WATCH_CLK_I(wclk), .IRQ_N_O(irq_n), .TRIG_O(trig), .P1_IN_I(p1_lvl), .P1_OUT_O(p1_out),
        .P1_OE_O(p1_oe), .P1_PULLUP_O(p1_pu), .P2_IN_I(p2_lvl), .P2_OUT_O(p2_out), .P2_OE_O(p2_oe));
    ppf_pin_model ppf_pin_model_i (
        .clk_i(clk), .p1_out_i(p1_out), .p1_oe_i(p1_oe), .p1_pu_i(p1_pu), .p1_ext_i(p1_ext),
        .p1_ext_en_i(p1_ext_en), .p1_lvl_o(p1_lvl), .p2_out_i(p2_out), .p2_oe_i(p2_oe),
        .p2_ext_i(p2_ext), .p2_lvl_o(p2_lvl), .pwm_o(pwm), .wclk_o(wclk));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up;
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle; ack and read data sampled at a rising edge, request released at that edge
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rv);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat_w} <= {1'b1, 1'b1, w, idx, 2'b00, 4'h1, 24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) chk(8'h00, 8'h01);
        rv = dat_r[7:0];
        {cyc, stb, we} <= 3'h0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, i, d, x);
    endtask : wr

    task automatic rd(input logic [15:0] i, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, i, 8'h00, x);
        chk(x, e);
    endtask : rd

    task automatic t_reset;
        chk(p1_pu, 8'h00);
        rd(IDX_P1_MODE, 8'h04);
        rd(IDX_P1_PULLUP, 8'h00);
        rd(IDX_P1_DIR, 8'hff);
        rd(IDX_P2_DIR, 8'hff);
        chk({5'h00, p2_oe}, 8'h00);
        wr(IDX_P2_DIR, 8'h07);
        rd(IDX_P2_DATA, 8'h00);
        rd(16'hff00, 8'h00);
        wr(IDX_P1_MODE, 8'hff);
        rd(IDX_P1_MODE, 8'hf5);
        wr(IDX_P1_MODE, 8'h00);
        rd(IDX_P1_MODE, 8'h04);
    endtask : t_reset

    task automatic t_port2;
        wr(IDX_P2_DATA, 8'hff);
        rd(IDX_P2_DATA, 8'h07);
        chk({5'h00, p2_oe}, 8'h07);
        chk({5'h00, p2_out}, 8'h07);
        p2_ext <= 3'h4;
        wr(IDX_P2_DIR, 8'h02);
        repeat (3) @(posedge clk);
        rd(IDX_P2_DATA, 8'h06);
    endtask : t_port2

    task automatic t_port1;
        wr(IDX_P1_DIR, 8'hf1);
        wr(IDX_P1_DATA, 8'ha1);
        chk(p1_oe & 8'hf1, 8'hf1);
        chk(p1_out & 8'hf1, 8'ha1);
        rd(IDX_P1_DATA, 8'ha1);
        wr(IDX_P1_PULLUP, 8'hf1);
        chk(p1_pu, 8'h00);
        p1_ext_en <= 8'hc0;
        p1_ext <= 8'h40;
        wr(IDX_P1_DIR, 8'h31);
        chk(p1_pu, 8'hc0);
        rd(IDX_P1_DATA, 8'h61);
    endtask : t_port1

    // standby floats the port; hold modes freeze it; subactive works as active
    task automatic t_power;
        ppf_pwr_e hold [3];
        hold = '{PM_SLEEP, PM_SUBSLEEP, PM_WATCH};
        pm <= PM_STANDBY;
        repeat (3) @(posedge clk);
        chk(p1_oe, 8'h00);
        chk(p1_pu, 8'hc0);
        for (int k = 0; k < 3; k++) begin
            pm <= PM_ACTIVE;
            wr(IDX_P1_DATA, 8'ha1);
            pm <= hold[k];
            wr(IDX_P1_DATA, 8'h00);
            chk(p1_out & 8'h31, 8'h21);
            chk(p1_oe & 8'hf1, 8'h31);
        end
        pm <= PM_SUBACTIVE;
        wr(IDX_P1_DATA, 8'h00);
        chk(p1_out & 8'h31, 8'h00);
        pm <= PM_ACTIVE;
    endtask : t_power

    // peripheral selections override the direction bits both ways
    task automatic t_periph;
        logic pw, wc;
        p1_ext_en <= 8'he0;
        p1_ext <= 8'ha0;
        wr(IDX_P1_DIR, 8'he0);
        wr(IDX_P1_MODE, 8'hf1);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(p1_oe & 8'hf1, 8'h11);
        chk({5'h00, irq_n}, 8'h05);
        chk({7'h00, trig}, 8'h01);
        pw = pwm;
        wc = wclk;
        repeat (6) begin
            @(negedge clk);
            chk({6'h00, p1_out[4], p1_out[0]}, {6'h00, pw, wc});
            pw = pwm;
            wc = wclk;
        end
        wr(IDX_P1_MODE, 8'h04);
        repeat (4) @(posedge clk);
        chk({5'h00, irq_n}, 8'h07);
        chk({7'h00, trig}, 8'h00);
        chk(p1_oe & 8'hf1, 8'he0);
    endtask : t_periph

    // watchdog well beyond the roughly 150 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin
        {rst_n, cyc, stb, we, adr, sel, dat_w} = '0;
        {pm, p1_ext, p1_ext_en, p2_ext} = '0;
        repeat (8) @(posedge clk);
        chk(p1_oe, 8'h00);
        rst_n <= 1'b1;
        t_reset();
        t_port2();
        t_port1();
        t_power();
        t_periph();
        wrap_up();
    end
endmodule : ppf_port_pin_function_select_tb_top
